/* File: design/uhlp_pkg.sv */
// uhlp_pkg: offsets, field layout and reset values of the list pointer bank
package uhlp_pkg;

  // ==========================================================================
  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] UHLP_CTRL_HEAD_OFS = 8'h00;
  localparam logic [7:0] UHLP_CTRL_CUR_OFS  = 8'h04;
  localparam logic [7:0] UHLP_BULK_HEAD_OFS = 8'h08;
  localparam logic [7:0] UHLP_BULK_CUR_OFS  = 8'h0C;
  localparam logic [7:0] UHLP_DONE_TOP_OFS  = 8'h10;

  // ==========================================================================
  // field layout: pointer in bits 31..4, bits 3..0 reserved
  localparam int         UHLP_PTR_LSB   = 4;
  localparam int         UHLP_PTR_W     = 28;
  localparam logic [3:0] UHLP_RSVD_VAL  = 4'h0;
  localparam logic [27:0] UHLP_PTR_RST  = 28'h0000000;
  localparam logic [27:0] UHLP_PTR_NULL = 28'h0000000;

  // register select codes
  typedef enum logic [2:0]
  {
    UHLP_SEL_NONE      = 3'b000,
    UHLP_SEL_CTRL_HEAD = 3'b001,
    UHLP_SEL_CTRL_CUR  = 3'b010,
    UHLP_SEL_BULK_HEAD = 3'b011,
    UHLP_SEL_BULK_CUR  = 3'b100,
    UHLP_SEL_DONE_TOP  = 3'b101
  } uhlp_sel_t;

endpackage

/* File: design/uhlp_ptr_reg.sv */
// uhlp_ptr_reg: one 28-bit list pointer with software and engine load ports
`timescale 1ns/1ns
module uhlp_ptr_reg
  import uhlp_pkg::*;
#(
  parameter int PTR_W = UHLP_PTR_W
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // software load
  input  wire logic             sw_we,
  input  wire logic [PTR_W-1:0] sw_val,
  // engine load, wins over software
  input  wire logic             hw_we,
  input  wire logic [PTR_W-1:0] hw_val,
  // stored pointer
  output logic      [PTR_W-1:0] ptr
);

  logic [PTR_W-1:0] ptr_r;
  logic [PTR_W-1:0] ptr_nxt;

  // engine update beats software so an in-flight walk is never lost
  always_comb
  begin
    ptr_nxt = ptr_r;
    if (hw_we)
      ptr_nxt = hw_val;
    else if (sw_we)
      ptr_nxt = sw_val;
  end

  // pointer flop, null after reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ptr_r <= PTR_W'(UHLP_PTR_RST);
    else
      ptr_r <= ptr_nxt;
  end

  assign ptr = ptr_r;

endmodule

/* File: design/uhlp_regs.sv */
// uhlp_regs: control/bulk list and done queue pointer register bank
`timescale 1ns/1ns

module uhlp_regs
  import uhlp_pkg::*;
#(
  parameter int PTR_W = UHLP_PTR_W
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  // list engine: control current update
  input  wire logic             eng_ctrl_load,
  input  wire logic [PTR_W-1:0] eng_ctrl_addr,
  input  wire logic             eng_ctrl_end,
  // list engine: bulk current update
  input  wire logic             eng_bulk_load,
  input  wire logic [PTR_W-1:0] eng_bulk_addr,
  input  wire logic             eng_bulk_end,
  // list engine: done queue
  input  wire logic             eng_done_push,
  input  wire logic [PTR_W-1:0] eng_done_addr,
  input  wire logic             eng_done_clr,
  // pointers toward the list engine
  output logic      [PTR_W-1:0] control_head_addr,
  output logic      [PTR_W-1:0] control_current_addr,
  output logic      [PTR_W-1:0] bulk_head_addr,
  output logic      [PTR_W-1:0] bulk_current_addr,
  output logic      [PTR_W-1:0] done_queue_top_addr
);

  // ==========================================================================
  // register map, byte offsets, one word each
  //   0x00  control head     software read/write
  //   0x04  control current  software and engine
  //   0x08  bulk head        software read/write
  //   0x0C  bulk current     software and engine
  //   0x10  done top         engine only, writes dropped
  //   other offsets read zero and swallow writes
  // every pointer holds address bits 31..4; descriptors sit on 16-byte
  // boundaries, so the low nibble carries nothing and is never stored
  // a stored zero is the null pointer: end of a list, or an empty queue
  //
  // same-cycle priorities
  //   engine end over engine load: a finished walk always leaves null
  //   engine update over a software write: the walk's newest position is
  //   never rolled back by a stale value from the driver
  //   done push over done clear: a descriptor retired in the clearing
  //   cycle stays visible to software
  //
  // limitation: nothing locks the current pointers during a walk; the
  // driver should stop list processing before rewriting them

  // ==========================================================================
  // address decode
  function automatic uhlp_sel_t uhlp_decode(input logic [7:0] a);
    uhlp_sel_t s;
    s = UHLP_SEL_NONE;
    case (a)
      UHLP_CTRL_HEAD_OFS: s = UHLP_SEL_CTRL_HEAD;
      UHLP_CTRL_CUR_OFS:  s = UHLP_SEL_CTRL_CUR;
      UHLP_BULK_HEAD_OFS: s = UHLP_SEL_BULK_HEAD;
      UHLP_BULK_CUR_OFS:  s = UHLP_SEL_BULK_CUR;
      UHLP_DONE_TOP_OFS:  s = UHLP_SEL_DONE_TOP;
      default:            s = UHLP_SEL_NONE;
    endcase
    return s;
  endfunction

  // decoded selects and trimmed write data
  uhlp_sel_t        wsel;
  uhlp_sel_t        rsel;
  logic [PTR_W-1:0] wptr;
  // stored pointers from the register cells
  logic [PTR_W-1:0] chead_q;
  logic [PTR_W-1:0] ccur_q;
  logic [PTR_W-1:0] bhead_q;
  logic [PTR_W-1:0] bcur_q;
  // done queue top and read data flops
  logic [PTR_W-1:0] done_r;
  logic [PTR_W-1:0] done_nxt;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;
  // engine values after the end-of-list override
  logic [PTR_W-1:0] ctrl_hw_val;
  logic [PTR_W-1:0] bulk_hw_val;

  assign wsel = reg_wr ? uhlp_decode(reg_addr) : UHLP_SEL_NONE;
  assign rsel = uhlp_decode(reg_addr);
  // low nibble of written data is dropped
  assign wptr = reg_wdata[31:UHLP_PTR_LSB];

  // end-of-list walk forces a null pointer
  assign ctrl_hw_val = eng_ctrl_end ? PTR_W'(UHLP_PTR_NULL)
                                    : eng_ctrl_addr;
  assign bulk_hw_val = eng_bulk_end ? PTR_W'(UHLP_PTR_NULL)
                                    : eng_bulk_addr;

  // ==========================================================================
  // pointer registers
  // control head: software only, engine port tied off
  uhlp_ptr_reg #(.PTR_W(PTR_W)) u_chead
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .sw_we    (wsel == UHLP_SEL_CTRL_HEAD),
    .sw_val   (wptr),
    .hw_we    (1'b0),
    .hw_val   (PTR_W'(UHLP_PTR_NULL)),
    .ptr      (chead_q)
  );

  // control current: moved by the walk, settable by software
  uhlp_ptr_reg #(.PTR_W(PTR_W)) u_ccur
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .sw_we    (wsel == UHLP_SEL_CTRL_CUR),
    .sw_val   (wptr),
    .hw_we    (eng_ctrl_load | eng_ctrl_end),
    .hw_val   (ctrl_hw_val),
    .ptr      (ccur_q)
  );

  // bulk head: software only, engine port tied off
  uhlp_ptr_reg #(.PTR_W(PTR_W)) u_bhead
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .sw_we    (wsel == UHLP_SEL_BULK_HEAD),
    .sw_val   (wptr),
    .hw_we    (1'b0),
    .hw_val   (PTR_W'(UHLP_PTR_NULL)),
    .ptr      (bhead_q)
  );

  // bulk current: moved by the walk, settable by software
  uhlp_ptr_reg #(.PTR_W(PTR_W)) u_bcur
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .sw_we    (wsel == UHLP_SEL_BULK_CUR),
    .sw_val   (wptr),
    .hw_we    (eng_bulk_load | eng_bulk_end),
    .hw_val   (bulk_hw_val),
    .ptr      (bcur_q)
  );

  // ==========================================================================
  // done queue top: engine only, software writes are ignored
  always_comb
  begin
    done_nxt = done_r;
    if (eng_done_push)
      done_nxt = eng_done_addr;
    else if (eng_done_clr)
      done_nxt = PTR_W'(UHLP_PTR_NULL);
  end

  // done top register, empty queue after reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      done_r <= PTR_W'(UHLP_PTR_RST);
    else
      done_r <= done_nxt;
  end

  // ==========================================================================
  // read data, valid only in the cycle after the read strobe
  // unmapped or idle reads return zero, so the port idles low
  always_comb
  begin
    rdata_nxt = 32'h00000000;
    if (reg_rd)
    begin
      case (rsel)
        UHLP_SEL_CTRL_HEAD: rdata_nxt = {chead_q, UHLP_RSVD_VAL};
        UHLP_SEL_CTRL_CUR:  rdata_nxt = {ccur_q, UHLP_RSVD_VAL};
        UHLP_SEL_BULK_HEAD: rdata_nxt = {bhead_q, UHLP_RSVD_VAL};
        UHLP_SEL_BULK_CUR:  rdata_nxt = {bcur_q, UHLP_RSVD_VAL};
        UHLP_SEL_DONE_TOP:  rdata_nxt = {done_r, UHLP_RSVD_VAL};
        default:            rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // read data register, one cycle of latency
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rdata_r <= 32'h00000000;
    else
      rdata_r <= rdata_nxt;
  end

  // ==========================================================================
  // outputs straight from flip-flops
  // the pointers also feed the list engine directly
  assign reg_rdata            = rdata_r;
  assign control_head_addr    = chead_q;
  assign control_current_addr = ccur_q;
  assign bulk_head_addr       = bhead_q;
  assign bulk_current_addr    = bcur_q;
  assign done_queue_top_addr  = done_r;

endmodule

/* File: verif/uhlp_regs_props.sv */
// uhlp_regs_props: port checks of the list pointer bank
`timescale 1ns/1ns
module uhlp_regs_props
  import uhlp_pkg::*;
(
  // clock, reset, register port
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // engine strobes
  input wire logic        eng_ctrl_load,
  input wire logic [27:0] eng_ctrl_addr,
  input wire logic        eng_ctrl_end,
  input wire logic        eng_bulk_end,
  input wire logic        eng_done_push,
  input wire logic [27:0] eng_done_addr,
  input wire logic        eng_done_clr,
  // pointers
  input wire logic [27:0] control_head_addr,
  input wire logic [27:0] control_current_addr,
  input wire logic [27:0] bulk_head_addr,
  input wire logic [27:0] bulk_current_addr,
  input wire logic [27:0] done_queue_top_addr
);
  // ==========================================================
  // one domain; reset masks every check
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [27:0] wd_hi;
  assign wd_hi = reg_wdata[31:4]; // low nibble never stored
  a_ctrl_load: assert property (
    eng_ctrl_load && !eng_ctrl_end |=> control_current_addr
    == $past(eng_ctrl_addr)) else $error("ctrl load lost");
  a_ctrl_end: assert property (
    eng_ctrl_end ##1 1'b1 |-> control_current_addr == 28'h0)
    else $error("ctrl end not zero");
  a_bulk_head: assert property (
    reg_wr && reg_addr == UHLP_BULK_HEAD_OFS |=>
    bulk_head_addr == $past(wd_hi)) else $error("bulk head write");
  a_rd_bulk: assert property (
    reg_rd && reg_addr == UHLP_BULK_CUR_OFS |=> reg_rdata ==
    {$past(bulk_current_addr), 4'h0}) else $error("bulk read");
  a_bulk_end: assert property (
    eng_bulk_end |=> bulk_current_addr == 28'h0)
    else $error("bulk end not zero");
  a_done_push: assert property (
    eng_done_push |=> done_queue_top_addr == $past(eng_done_addr))
    else $error("done push lost");
  a_done_clr: assert property (
    eng_done_clr && !eng_done_push |=> done_queue_top_addr == 28'h0)
    else $error("done clear not zero");
  a_ctrl_head: assert property (
    reg_wr && reg_addr == UHLP_CTRL_HEAD_OFS |=>
    control_head_addr == $past(wd_hi)) else $error("ctrl head write");
  a_rsvd_zero: assert property (
    reg_rdata[3:0] == UHLP_RSVD_VAL) else $error("reserved bits set");
endmodule
bind uhlp_regs uhlp_regs_props u_props (.*);

/* File: verif/uhlp_list_model.sv */
// uhlp_list_model: bulk descriptor list, walked one step at a time
`timescale 1ns/1ns
module uhlp_list_model
(
  // clock, reset, walk request
  input  wire logic   core_clk,
  input  wire logic   sys_rst,
  input  wire logic   step,
  // engine strobes toward the bank
  output logic        ld,
  output logic        fin,
  output logic [27:0] addr
);
  // ==========================================================
  logic [1:0] idx_r;
  // three descriptors, then end; idle address inverts, no stale value
  always_ff @(posedge core_clk)
  begin
    ld    <= step && idx_r != 2'h3;
    fin   <= step && idx_r == 2'h3;
    addr  <= sys_rst ? 28'h0 : step ? {26'h2800000, idx_r} : ~addr;
    idx_r <= sys_rst ? 2'h0 : idx_r + 2'(step);
  end
endmodule

/* File: verif/uhlp_regs_tb_top.sv */
// uhlp_regs_tb_top: self-checking bench of the list pointer bank
`timescale 1ns/1ns
module uhlp_regs_tb_top import uhlp_pkg::*;;
  // ==========================================================
  logic        core_clk, sys_rst, reg_wr, reg_rd, b_ld, b_fin;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [4:0]  ev; // step, ctrl load, ctrl end, done push, done clr
  logic [27:0] ev_addr, b_addr;
  int          error_cnt, compares;
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  uhlp_regs dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_ctrl_load(ev[3]),
    .eng_ctrl_addr(ev_addr), .eng_ctrl_end(ev[2]), .eng_bulk_load(b_ld),
    .eng_bulk_addr(b_addr), .eng_bulk_end(b_fin), .eng_done_push(ev[1]),
    .eng_done_addr(ev_addr), .eng_done_clr(ev[0]),
    .control_head_addr(), .control_current_addr(), .bulk_head_addr(),
    .bulk_current_addr(), .done_queue_top_addr());
  uhlp_list_model mem (.core_clk(core_clk), .sys_rst(sys_rst),
    .step(ev[4]), .ld(b_ld), .fin(b_fin), .addr(b_addr));
  // expectations: pointer with zero nibble, list slot address
  function automatic logic [31:0] xp(input logic [27:0] p);
    return {p, 4'h0};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  task automatic pulse(input logic [4:0] k, input logic [27:0] v);
    @(posedge core_clk);
    {ev, ev_addr} <= {k, v};
    @(posedge core_clk);
    {ev, ev_addr} <= {5'h00, ~v}; // no stale address while idle
  endtask
  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 40'h0};
    {ev, ev_addr, error_cnt, compares} = '0;
    d = $urandom(46927);
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    // reset values, unmapped place too
    for (int a = 0; a < 24; a += 4) rd(8'(a), 32'h0);
    $display("test reset done");
    // back to back write and read of every writable pointer
    for (int i = 0; i < 8; i++)
    begin
      d = $urandom;
      wr(8'(i % 4 * 4), d);
      rd(8'(i % 4 * 4), {d[31:4], 4'h0});
    end
    wr(UHLP_DONE_TOP_OFS, d);
    rd(UHLP_DONE_TOP_OFS, 32'h0);
    $display("test write done");
    // walk three descriptors, then past the end
    for (int i = 0; i < 4; i++)
    begin
      pulse(5'h10, 28'h0);
      rd(UHLP_BULK_CUR_OFS, i < 3 ? xp({26'h2800000, 2'(i)}) : 0);
    end
    d = $urandom;
    pulse(5'h08, d[27:0]);
    rd(UHLP_CTRL_CUR_OFS, xp(d[27:0]));
    pulse(5'h04, d[27:0]);
    rd(UHLP_CTRL_CUR_OFS, 32'h0);
    pulse(5'h02, d[31:4]);
    rd(UHLP_DONE_TOP_OFS, xp(d[31:4]));
    pulse(5'h01, d[31:4]);
    rd(UHLP_DONE_TOP_OFS, 32'h0);
    $display("test engine done");
    // same-cycle corners: end over load, push over clear, engine over write
    pulse(5'h0C, d[27:0]);
    rd(UHLP_CTRL_CUR_OFS, 32'h0);
    pulse(5'h03, d[27:0]);
    rd(UHLP_DONE_TOP_OFS, xp(d[27:0]));
    fork
      wr(UHLP_CTRL_CUR_OFS, ~d);
      pulse(5'h08, d[27:0]);
    join
    rd(UHLP_CTRL_CUR_OFS, xp(d[27:0]));
    $display("test priority done");
    // second reset in mid-run clears everything written so far
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 24; a += 4) rd(8'(a), 32'h0);
    $display("test mid-run reset done");
    give_verdict();
  end
  // watchdog: run needs about 110 cycles
  initial
  begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    give_verdict();
  end
endmodule
